// ---- design/pwlc_pkg.sv ----
package pwlc_pkg;

	// ----------------------------------------------------------------
	// Register map (byte offsets, one 32-bit word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] PWLC_OFF_STATUS   = 8'h00;
	localparam logic [7:0] PWLC_OFF_RATIO    = 8'h04;
	localparam logic [7:0] PWLC_OFF_LPCTRL   = 8'h08;
	localparam logic [7:0] PWLC_OFF_WAKESEL  = 8'h0c;
	localparam logic [7:0] PWLC_OFF_WDCOUNT  = 8'h10;
	localparam logic [7:0] PWLC_OFF_WDKEY    = 8'h14;
	localparam logic [7:0] PWLC_OFF_WDCTRL   = 8'h18;
	localparam logic [7:0] PWLC_OFF_LPSTATE  = 8'h1c;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int PWLC_ST_DIVBYP  = 0;
	localparam int PWLC_ST_PWRDN   = 1;
	localparam int PWLC_ST_MISSING = 2;
	localparam int PWLC_ST_LOCKED  = 3;
	localparam int PWLC_ST_LIMP    = 4;
	localparam int PWLC_LP_SEL_LSB = 0;
	localparam int PWLC_LP_QUAL_LSB = 8;
	localparam int PWLC_WD_DIS     = 0;
	localparam int PWLC_WD_WAKE    = 1;

	// ----------------------------------------------------------------
	// Values and reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] PWLC_RATIO_BYPASS = 4'h0;
	localparam logic [3:0] PWLC_RATIO_MAX    = 4'ha;
	localparam logic [1:0] PWLC_LPSEL_IDLE   = 2'h0;
	localparam logic [1:0] PWLC_LPSEL_STBY   = 2'h1;
	localparam logic [5:0] PWLC_QUAL_RESET   = 6'h02;
	localparam logic [7:0] PWLC_WD_KEY_ARM   = 8'h55;
	localparam logic [7:0] PWLC_WD_KEY_FIRE  = 8'haa;
	localparam logic [7:0] PWLC_WD_MAX       = 8'hff;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned PWLC_LOCK_CYCLES   = 131072;
	localparam int unsigned PWLC_WD_PULSE      = 512;
	localparam int unsigned PWLC_WD_PRESCALE   = 512;
	localparam int unsigned PWLC_MISS_WINDOW   = 64;
	localparam int unsigned PWLC_MCLK_RST_LEN  = 16;
	localparam int unsigned PWLC_EXIT_RECOG    = 2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SRC_OSC_DIV2,
		SRC_OSC,
		SRC_PLL,
		SRC_LIMP
	} pwlc_clksrc_t;

	typedef enum logic [1:0] {
		LP_RUN,
		LP_IDLE,
		LP_STANDBY,
		LP_HALT
	} pwlc_lpstate_t;

	typedef struct packed {
		logic       disable_;
		logic       wakeMode;
	} pwlc_wdctrl_t;

	typedef struct packed {
		logic [5:0] qualCycles;
		logic [1:0] select;
	} pwlc_lpctrl_t;

	typedef struct packed {
		logic       cpuClkInRun;
		logic       cpuClkOutRun;
		logic       periphClkRun;
		logic       oscRun;
		logic       pllRun;
		logic       holdPins;
		logic       scanPortRun;
	} pwlc_clkgate_t;

endpackage

// ---- design/pwlc_watchdog.sv ----
`timescale 1ns/1ps
module pwlc_watchdog
	import pwlc_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	// Control
	input  wire logic       tick,
	input  wire logic       run,
	input  wire logic       wakeMode,
	// Key port
	input  wire logic       keyWrite,
	input  wire logic [7:0] keyData,
	// Results
	output logic [7:0]      count,
	output logic            wdResetN,
	output logic            wdWakeEvent
);

	// ----------------------------------------------------------------
	// Key sequence and counter
	// ----------------------------------------------------------------
	logic        armed;
	logic [9:0]  pulseCnt;
	wire  logic  keyFire = keyWrite && armed && (keyData == PWLC_WD_KEY_FIRE);
	wire  logic  expire  = run && tick && (count == PWLC_WD_MAX);

	// A wrong key breaks the sequence, so 0x55 must come right before 0xaa
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			armed <= 1'b0;
		end else if (keyWrite) begin
			armed <= (keyData == PWLC_WD_KEY_ARM);
		end
	end

	// A key clear wins; otherwise the counter holds whenever run or tick is low
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			count <= 8'h00;
		end else if (keyFire) begin
			count <= 8'h00; // RULE_12
		end else if (run && tick) begin
			count <= count + 8'h01; // RULE_09
		end
	end

	// ----------------------------------------------------------------
	// Expiry: long low reset pulse or one-cycle wake
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pulseCnt    <= 10'h000;
			wdWakeEvent <= 1'b0;
		end else begin
			wdWakeEvent <= expire && wakeMode;
			if (expire && !wakeMode) begin
				pulseCnt <= 10'(PWLC_WD_PULSE); // RULE_11
			end else if (pulseCnt != 10'h000) begin
				pulseCnt <= pulseCnt - 10'h001;
			end
		end
	end

	assign wdResetN = (pulseCnt == 10'h000); // RULE_11

endmodule

// ---- design/pwlc_clock_ctrl.sv ----
`timescale 1ns/1ps
//
// Function
// [RULE_01] Divide bypass only set while ratio is zero
// [RULE_02] Power-down stops PLL, clock from oscillator
// [RULE_03] Reset and zero ratio select bypass
// [RULE_04] Bypass routes around PLL, PLL stays powered
// [RULE_05] Nonzero ratio gives oscillator times n over two
// [RULE_06] Ratio write forces bypass until lock
// [RULE_07] Lost oscillator after first seen gives limp clock
// [RULE_08] Bypass switches to limp clock automatically
// [RULE_09] Watchdog holds while input clock missing
// [RULE_10] Clock loss raises reset and sticky flag
// [RULE_11] Watchdog maximum drives 512-cycle low pulse
// [RULE_12] Key 0x55 then 0xaa clears watchdog
// [RULE_13] Standby stops peripherals, watchdog keeps waking
// [RULE_14] Idle watchdog wake raises CPU interrupt
// [RULE_15] Idle keeps clocks, exits on listed sources
// [RULE_16] Standby stops CPU clocks, listed exit sources
// [RULE_17] Halt stops oscillator, PLL and watchdog
// [RULE_18] Exit signals active low, held to count
// [RULE_19] Standby wake pins qualified programmed cycles
// [RULE_20] Low-power modes hold output pin states
// [RULE_21] Scan port keeps working while CPU stopped
// [RULE_22] Ratio four bits, reserved codes rejected
// [RULE_23] PLL locked after 131072 oscillator cycles
// [RULE_24] Missing oscillator found by edge-free window
module pwlc_clock_ctrl
	import pwlc_pkg::*;
#(
	parameter int unsigned LOCK_CYCLES = PWLC_LOCK_CYCLES
)(
	// Clock and reset
	input  wire logic          sys_clk,
	input  wire logic          rstn,
	// Register port
	input  wire logic [7:0]    regAddr,
	input  wire logic [31:0]   regWdata,
	input  wire logic          regWrite,
	input  wire logic          regRead,
	output logic [31:0]        regRdata,
	// Pins, asynchronous
	input  wire logic          ext_clock_pin,
	input  wire logic          ext_reset_n,
	input  wire logic          ext_nmi_n,
	input  wire logic          dbg_wake_n,
	input  wire logic [31:0]   gpioA,
	// CPU side, same clock
	input  wire logic          idleExec,
	input  wire logic          irqPending,
	// Clock path control
	output pwlc_clksrc_t       clkSrc,
	output logic [3:0]         pllMult,
	output pwlc_clkgate_t      clkGate,
	output pwlc_lpstate_t      lpState,
	// Events and resets
	output logic               wdIrq,
	output logic               cpuWake,
	output logic               devResetN
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [35:0] syncA;
	logic [35:0] syncB;

	// Two flops per pin; only syncB feeds logic
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			syncA <= {4'hf, 32'hffffffff};
			syncB <= {4'hf, 32'hffffffff};
		end else begin
			syncA <= {ext_clock_pin, ext_reset_n, ext_nmi_n, dbg_wake_n, gpioA};
			syncB <= syncA;
		end
	end

	wire logic        oscPin  = syncB[35];
	wire logic        resetLo = !syncB[34];
	wire logic        nmiLo   = !syncB[33];
	wire logic        dbgLo   = !syncB[32];
	wire logic [31:0] gpioS   = syncB[31:0];

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic          divBypass;
	logic          pllPowerDown;
	logic          missingFlag;
	logic [3:0]    ratio;
	pwlc_lpctrl_t  lpCtrl;
	logic [31:0]   wakeSel;
	pwlc_wdctrl_t  wdCtrl;
	logic          pllLocked;
	logic          oscMissing;
	logic [7:0]    wdCount;
	logic          wdResetN;
	logic          wdWakeEvent;

	wire logic wrStatus  = regWrite && (regAddr == PWLC_OFF_STATUS);
	wire logic wrRatio   = regWrite && (regAddr == PWLC_OFF_RATIO);
	wire logic wrLpCtrl  = regWrite && (regAddr == PWLC_OFF_LPCTRL);
	wire logic wrWakeSel = regWrite && (regAddr == PWLC_OFF_WAKESEL);
	wire logic wrWdKey   = regWrite && (regAddr == PWLC_OFF_WDKEY);
	wire logic wrWdCtrl  = regWrite && (regAddr == PWLC_OFF_WDCTRL);

	// Ratio must be legal, and frozen once divide bypass is set
	wire logic ratioOk   = (regWdata[3:0] <= PWLC_RATIO_MAX) && !divBypass; // RULE_22 RULE_01
	wire logic ratioZero = (ratio == PWLC_RATIO_BYPASS);
	wire logic ratioTake = wrRatio && ratioOk; // RULE_06

	// Status and ratio; bypass and power-down only accepted at ratio zero
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			divBypass    <= 1'b0;
			pllPowerDown <= 1'b0;
			ratio        <= PWLC_RATIO_BYPASS; // RULE_03
		end else begin
			if (wrStatus && ratioZero) begin
				divBypass    <= regWdata[PWLC_ST_DIVBYP]; // RULE_01
				pllPowerDown <= regWdata[PWLC_ST_PWRDN]; // RULE_02
			end
			if (ratioTake) begin
				ratio <= regWdata[3:0];
			end
		end
	end

	// Configuration words
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			lpCtrl  <= '{qualCycles: PWLC_QUAL_RESET, select: PWLC_LPSEL_IDLE};
			wakeSel <= 32'h00000000;
			wdCtrl  <= '{disable_: 1'b0, wakeMode: 1'b0};
		end else begin
			if (wrLpCtrl) begin
				lpCtrl.select     <= regWdata[PWLC_LP_SEL_LSB +: 2];
				lpCtrl.qualCycles <= regWdata[PWLC_LP_QUAL_LSB +: 6];
			end
			if (wrWakeSel) begin
				wakeSel <= regWdata;
			end
			if (wrWdCtrl) begin
				wdCtrl.disable_ <= regWdata[PWLC_WD_DIS];
				wdCtrl.wakeMode <= regWdata[PWLC_WD_WAKE];
			end
		end
	end

	// Read mux, answer one cycle after the strobe
	logic [31:0] rdMux;
	always_comb begin
		rdMux = 32'h00000000;
		case (regAddr)
			PWLC_OFF_STATUS:  rdMux = {27'h0, oscMissing, pllLocked,
				missingFlag, pllPowerDown, divBypass};
			PWLC_OFF_RATIO:   rdMux = {28'h0000000, ratio};
			PWLC_OFF_LPCTRL:  rdMux = {18'h0, lpCtrl.qualCycles, 6'h00, lpCtrl.select};
			PWLC_OFF_WAKESEL: rdMux = wakeSel;
			PWLC_OFF_WDCOUNT: rdMux = {24'h000000, wdCount};
			PWLC_OFF_WDCTRL:  rdMux = {30'h0, wdCtrl.wakeMode, wdCtrl.disable_};
			PWLC_OFF_LPSTATE: rdMux = {30'h0, lpState};
			default:          rdMux = 32'h00000000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			regRdata <= 32'h00000000;
		end else begin
			regRdata <= regRead ? rdMux : 32'h00000000;
		end
	end

	// ----------------------------------------------------------------
	// Oscillator monitor
	// ----------------------------------------------------------------
	logic        oscPrev;
	logic        oscSeen;
	logic [6:0]  missCnt;
	logic [4:0]  mclkRstCnt;
	wire  logic  oscEdge   = oscPin && !oscPrev;
	wire  logic  oscOff    = (lpState == LP_HALT); // oscillator deliberately off
	wire  logic  missHit   = (missCnt == 7'(PWLC_MISS_WINDOW)) && oscSeen && !oscOff;
	wire  logic  missStart = missHit && !oscMissing;

	// Edge-free window marks the input lost; the window is cleared during halt
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			oscPrev    <= 1'b1; // Same as synchroniser reset, so no false edge
			oscSeen    <= 1'b0;
			missCnt    <= 7'h00;
			oscMissing <= 1'b0;
		end else begin
			oscPrev <= oscPin;
			if (oscEdge || oscOff) begin
				missCnt    <= 7'h00;
				oscSeen    <= oscSeen || oscEdge;
				oscMissing <= 1'b0;
			end else if (missHit) begin
				oscMissing <= 1'b1; // RULE_24 RULE_07
			end else begin
				missCnt <= missCnt + 7'h01;
			end
		end
	end

	// Flag is sticky; a new loss wins over a write-one clear
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			missingFlag <= 1'b0;
			mclkRstCnt  <= 5'h00;
		end else begin
			if (missStart) begin
				missingFlag <= 1'b1; // RULE_10
			end else if (wrStatus && regWdata[PWLC_ST_MISSING]) begin
				missingFlag <= 1'b0;
			end
			if (missStart) begin
				mclkRstCnt <= 5'(PWLC_MCLK_RST_LEN); // RULE_10
			end else if (mclkRstCnt != 5'h00) begin
				mclkRstCnt <= mclkRstCnt - 5'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// PLL lock and source selection
	// ----------------------------------------------------------------
	logic [17:0] lockCnt;
	wire  logic  pllOn = !pllPowerDown && !oscOff;

	// Any accepted ratio write restarts lock; halt also loses lock
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			lockCnt   <= 18'h00000;
			pllLocked <= 1'b0;
		end else if (ratioTake || !pllOn || ratioZero) begin
			lockCnt   <= 18'h00000; // RULE_06
			pllLocked <= 1'b0;
		end else if (lockCnt == 18'(LOCK_CYCLES - 1)) begin
			pllLocked <= 1'b1; // RULE_23
		end else begin
			lockCnt <= lockCnt + 18'h00001;
		end
	end

	wire logic bypassSel = ratioZero || !pllLocked || pllPowerDown; // RULE_03 RULE_06
	wire logic limpSel   = oscMissing && !pllPowerDown; // RULE_07 RULE_08

	always_comb begin
		if (limpSel) begin
			clkSrc = SRC_LIMP; // RULE_08
		end else if (bypassSel) begin
			clkSrc = divBypass ? SRC_OSC : SRC_OSC_DIV2; // RULE_02 RULE_04
		end else begin
			clkSrc = SRC_PLL; // RULE_05
		end
	end

	assign pllMult = ratio; // RULE_05

	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	logic [8:0] wdDiv;
	wire  logic wdTick = (wdDiv == 9'(PWLC_WD_PRESCALE - 1));
	wire  logic wdRun  = !wdCtrl.disable_ && !oscMissing && !oscOff; // RULE_09 RULE_17

	// Prescaler runs on the oscillator rate, even in standby
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wdDiv <= 9'h000;
		end else if (!wdRun || wdTick) begin
			wdDiv <= 9'h000;
		end else begin
			wdDiv <= wdDiv + 9'h001; // RULE_13
		end
	end

	pwlc_watchdog u_watchdog (
		.sys_clk     (sys_clk),
		.rstn        (rstn),
		.tick        (wdTick),
		.run         (wdRun),
		.wakeMode    (wdCtrl.wakeMode),
		.keyWrite    (wrWdKey), // RULE_12
		.keyData     (regWdata[7:0]),
		.count       (wdCount),
		.wdResetN    (wdResetN),
		.wdWakeEvent (wdWakeEvent)
	);

	// Idle or running: wake goes to the interrupt expansion
	assign wdIrq = wdWakeEvent && (lpState == LP_RUN || lpState == LP_IDLE); // RULE_14

	assign devResetN = wdResetN && (mclkRstCnt == 5'h00); // RULE_10 RULE_11

	// ----------------------------------------------------------------
	// Low-power controller
	// ----------------------------------------------------------------
	pwlc_lpstate_t lpNext;
	logic [5:0]    gpioCnt;
	logic [1:0]    exitCnt;
	logic          wdWakeHeld;
	wire  logic    gpioLo  = |(~gpioS & wakeSel);
	wire  logic    idleSrc = resetLo || nmiLo || irqPending || wdWakeHeld; // RULE_15
	wire  logic    stbySrc = resetLo || nmiLo || dbgLo || wdWakeHeld; // RULE_16
	wire  logic    haltSrc = resetLo || nmiLo || dbgLo || gpioLo; // RULE_17
	logic          exitSrc;

	always_comb begin
		case (lpState)
			LP_IDLE:    exitSrc = idleSrc;
			LP_STANDBY: exitSrc = stbySrc;
			LP_HALT:    exitSrc = haltSrc;
			default:    exitSrc = 1'b0;
		endcase
	end

	// Short glitches drop back to the mode; only a held level wakes
	wire logic exitQual = exitSrc && (exitCnt == 2'(PWLC_EXIT_RECOG - 1)); // RULE_18
	wire logic gpioQual = (lpState == LP_STANDBY) && gpioLo
		&& (gpioCnt >= lpCtrl.qualCycles); // RULE_19
	wire logic wakeNow  = exitQual || gpioQual;

	always_comb begin
		lpNext = lpState;
		case (lpState)
			LP_RUN: begin
				if (idleExec) begin
					if (lpCtrl.select[1]) begin
						lpNext = LP_HALT;
					end else if (lpCtrl.select == PWLC_LPSEL_STBY) begin
						lpNext = LP_STANDBY;
					end else begin
						lpNext = LP_IDLE;
					end
				end
			end
			LP_IDLE, LP_STANDBY, LP_HALT: begin
				if (wakeNow) begin
					lpNext = LP_RUN;
				end
			end
			default: lpNext = LP_RUN;
		endcase
	end

	// Qualifier counters restart on any high sample
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			lpState    <= LP_RUN;
			exitCnt    <= 2'h0;
			gpioCnt    <= 6'h00;
			wdWakeHeld <= 1'b0;
			cpuWake    <= 1'b0;
		end else begin
			lpState <= lpNext;
			cpuWake <= wakeNow;
			exitCnt <= (exitSrc && !exitQual) ? exitCnt + 2'h1 : 2'h0; // RULE_18
			if (gpioLo && (lpState == LP_STANDBY) && !gpioQual) begin
				gpioCnt <= gpioCnt + 6'h01; // RULE_19
			end else begin
				gpioCnt <= 6'h00;
			end
			// One-cycle wake is stretched until it is recognised
			if (wdWakeEvent && lpState != LP_RUN) begin
				wdWakeHeld <= 1'b1; // RULE_13
			end else if (wakeNow || lpState == LP_RUN) begin
				wdWakeHeld <= 1'b0;
			end
		end
	end

	// Clock gates; pins are frozen rather than reset in any low-power mode
	assign clkGate.cpuClkInRun  = (lpState == LP_RUN || lpState == LP_IDLE); // RULE_15 RULE_16
	assign clkGate.cpuClkOutRun = (lpState == LP_RUN || lpState == LP_IDLE); // RULE_15
	assign clkGate.periphClkRun = (lpState == LP_RUN || lpState == LP_IDLE); // RULE_13
	assign clkGate.oscRun       = !oscOff; // RULE_17
	assign clkGate.pllRun       = pllOn; // RULE_02 RULE_04
	assign clkGate.holdPins     = (lpState != LP_RUN); // RULE_20
	assign clkGate.scanPortRun  = 1'b1; // RULE_21

endmodule

// ---- verif/pwlc_clock_ctrl_chk.sv ----
`timescale 1ns/1ps
module pwlc_clock_ctrl_chk
	import pwlc_pkg::*;
#(
	parameter int unsigned LOCK_CYCLES = PWLC_LOCK_CYCLES
)(
	// Clock and reset
	input wire logic          sys_clk,
	input wire logic          rstn,
	// Register port and CPU side
	input wire logic [7:0]    regAddr,
	input wire logic [31:0]   regWdata,
	input wire logic          regWrite,
	input wire logic          idleExec,
	// Pins and outputs
	input wire logic          ext_clock_pin,
	input wire pwlc_clksrc_t  clkSrc,
	input wire logic [3:0]    pllMult,
	input wire pwlc_clkgate_t clkGate,
	input wire pwlc_lpstate_t lpState,
	input wire logic          cpuWake,
	input wire logic          devResetN
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// --------
	// Helpers
	// --------
	logic        ratioWr;
	logic        pinMoved;
	logic [17:0] lockCnt;
	logic [9:0]  lowCnt;
	logic [7:0]  stillCnt;
	logic        pinQ;
	logic        seenOsc;
	// Legal ratio writes restart locking; reserved codes are refused by the block
	assign ratioWr = regWrite && regAddr == PWLC_OFF_RATIO && regWdata[3:0] <= 4'ha;
	assign pinMoved = pinQ != ext_clock_pin;

	// Cycles since a ratio write and length of the current reset pulse
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			lockCnt <= '0;
			lowCnt <= '0;
		end else begin
			lockCnt <= ratioWr ? '0 : lockCnt + {17'h0, ~&lockCnt};
			lowCnt <= devResetN ? '0 : lowCnt + 10'h1;
		end
	end

	// Oscillator pin sampled on the system clock; enough to see it stall
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pinQ <= 1'b0;
			seenOsc <= 1'b0;
			stillCnt <= '0;
		end else begin
			pinQ <= ext_clock_pin;
			seenOsc <= seenOsc | pinMoved;
			stillCnt <= pinMoved ? '0 : stillCnt + {7'h0, ~&stillCnt};
		end
	end

	// --------
	// Checks
	// --------
	a_scan_alive: assert property (clkGate.scanPortRun)
		else $error("scan port clock stopped");
	a_hold_pins: assert property (clkGate.holdPins == (lpState != LP_RUN))
		else $error("pin hold does not follow low-power state");
	a_idle_clocks: assert property (lpState == LP_IDLE |->
		clkGate.cpuClkInRun && clkGate.cpuClkOutRun && clkGate.oscRun)
		else $error("idle stopped a clock");
	a_stby_clocks: assert property (lpState == LP_STANDBY |->
		!clkGate.cpuClkInRun && !clkGate.periphClkRun && clkGate.oscRun)
		else $error("standby clock gating wrong");
	a_halt_clocks: assert property (lpState == LP_HALT |->
		!clkGate.oscRun && !clkGate.pllRun && !clkGate.cpuClkInRun)
		else $error("halt left oscillator or pll running");
	a_pll_mult: assert property (clkSrc == SRC_PLL |-> pllMult inside {[4'h1:4'ha]})
		else $error("pll selected with bad multiplier");
	a_ratio_bypass: assert property (ratioWr |=> (clkSrc != SRC_PLL) [*8])
		else $error("ratio write did not force bypass");
	a_lock_time: assert property ($rose(clkSrc == SRC_PLL) |-> lockCnt >= LOCK_CYCLES - 1)
		else $error("pll used before lock time");
	a_reset_len: assert property ($rose(devResetN) |->
		lowCnt == PWLC_MCLK_RST_LEN || lowCnt == PWLC_WD_PULSE)
		else $error("reset pulse length wrong");
	a_miss_reset: assert property (seenOsc && stillCnt == 8'h48 && lpState != LP_HALT |->
		!devResetN)
		else $error("lost oscillator gave no reset");
	a_wake_run: assert property (cpuWake |-> lpState == LP_RUN && $past(lpState) != LP_RUN)
		else $error("wake pulse without leaving low power");
	a_idle_entry: assert property (idleExec && lpState == LP_RUN |=> lpState != LP_RUN)
		else $error("idle request not taken");

	c_pll_on: cover property ($rose(clkSrc == SRC_PLL));
	c_limp: cover property (clkSrc == SRC_LIMP);
	c_halt_exit: cover property (lpState == LP_HALT ##1 lpState == LP_RUN);
endmodule

bind pwlc_clock_ctrl pwlc_clock_ctrl_chk #(
	.LOCK_CYCLES(LOCK_CYCLES)
) i_pwlc_clock_ctrl_chk (
	.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
	.regWrite(regWrite), .idleExec(idleExec), .ext_clock_pin(ext_clock_pin),
	.clkSrc(clkSrc), .pllMult(pllMult), .clkGate(clkGate), .lpState(lpState),
	.cpuWake(cpuWake), .devResetN(devResetN)
);

// ---- verif/pwlc_osc_model.sv ----
`timescale 1ns/1ps
module pwlc_osc_model #(
	parameter int HALF_NS = 25
)(
	// Control
	input  wire logic run,
	// Oscillator pin
	output logic      ext_clock_pin
);
	// Free source, phase unrelated to the system clock; stands still low
	// while stopped, as a halted crystal gives no edges at all
	initial begin
		ext_clock_pin = 1'b0;
		#3;
		forever begin
			#(HALF_NS);
			ext_clock_pin = run ? ~ext_clock_pin : 1'b0;
		end
	end
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench
	import pwlc_pkg::*;
;
	// Short lock count keeps the run brief
	localparam int unsigned LOCK = 16;
	logic          sys_clk = 1'b0;
	logic          rstn = 1'b0;
	logic          oscOn = 1'b1;
	logic [7:0]    regAddr = 8'h00;
	logic [31:0]   regWdata = 32'h0;
	logic          regWrite = 1'b0;
	logic          regRead = 1'b0;
	logic          ext_reset_n = 1'b1;
	logic          ext_nmi_n = 1'b1;
	logic          dbg_wake_n = 1'b1;
	logic [31:0]   gpioA = 32'hffffffff;
	logic          idleExec = 1'b0;
	logic          irqPending = 1'b0;
	logic [31:0]   regRdata;
	logic          ext_clock_pin;
	pwlc_clksrc_t  clkSrc;
	logic [3:0]    pllMult;
	pwlc_clkgate_t clkGate;
	pwlc_lpstate_t lpState;
	logic          wdIrq;
	logic          cpuWake;
	logic          devResetN;
	int            miscompares = 0;
	int            nChecks = 0;

	always #10 sys_clk = ~sys_clk;

	pwlc_clock_ctrl #(.LOCK_CYCLES(LOCK)) i_pwlc_clock_ctrl (
		.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.ext_clock_pin(ext_clock_pin), .ext_reset_n(ext_reset_n), .ext_nmi_n(ext_nmi_n),
		.dbg_wake_n(dbg_wake_n), .gpioA(gpioA), .idleExec(idleExec),
		.irqPending(irqPending), .clkSrc(clkSrc), .pllMult(pllMult), .clkGate(clkGate),
		.lpState(lpState), .wdIrq(wdIrq), .cpuWake(cpuWake), .devResetN(devResetN)
	);
	// Oscillator stops whenever the block turns it off
	pwlc_osc_model i_pwlc_osc_model (
		.run(oscOn && clkGate.oscRun),
		.ext_clock_pin(ext_clock_pin)
	);

	// ----------------
	// Bench tasks
	// ----------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic closeOut();
		$display("Checks %0d, mismatches %0d", nChecks, miscompares);
		if (miscompares == 0 && nChecks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge sys_clk);
		regWrite <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge sys_clk);
		regRead <= 1'b0;
		@(negedge sys_clk);
		d = regRdata;
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		chk(d & m, e);
	endtask

	// Exit sources: 0 reset, 1 nmi, 2 debugger, 3 selected gpio, 4 interrupt
	task automatic setSrc(input int s, input logic on);
		case (s)
			0: ext_reset_n <= ~on;
			1: ext_nmi_n <= ~on;
			2: dbg_wake_n <= ~on;
			3: gpioA[5] <= ~on;
			default: irqPending <= on;
		endcase
	endtask

	// Enter a mode, hold one source for a number of cycles, see where it ends
	task automatic tryWake(input logic [1:0] sel, input int s, input int hold, input logic exp);
		pwlc_lpstate_t mode;
		mode = (sel == 2'h0) ? LP_IDLE : (sel == 2'h1) ? LP_STANDBY : LP_HALT;
		wr(PWLC_OFF_LPCTRL, {18'h0, 6'h06, 6'h0, sel});
		@(posedge sys_clk);
		idleExec <= 1'b1;
		@(posedge sys_clk);
		idleExec <= 1'b0;
		@(negedge sys_clk);
		chk(lpState, mode);
		@(posedge sys_clk);
		setSrc(s, 1'b1);
		cyc(hold);
		setSrc(s, 1'b0);
		cyc(12);
		@(negedge sys_clk);
		chk(lpState, exp ? LP_RUN : mode);
		// A source valid in every mode brings the block back to run
		if (!exp) begin
			@(posedge sys_clk);
			setSrc(1, 1'b1);
			cyc(6);
			setSrc(1, 1'b0);
			cyc(6);
		end
	endtask

	// ----------------
	// Test sequence
	// ----------------
	initial begin
		logic [31:0] c1;
		int          n;
		cyc(5);
		rstn <= 1'b1;
		@(negedge sys_clk);
		chk(clkSrc, SRC_OSC_DIV2);
		chk({wdIrq, cpuWake, devResetN}, 3'h1);
		rdChk(PWLC_OFF_LPCTRL, 32'hffffffff, 32'h00000200);
		rdChk(PWLC_OFF_WAKESEL, 32'hffffffff, 32'h0);
		rdChk(PWLC_OFF_WDCTRL, 32'hffffffff, 32'h0);
		rdChk(8'h20, 32'hffffffff, 32'h0);
		wr(PWLC_OFF_RATIO, 32'h0000000b);
		rdChk(PWLC_OFF_RATIO, 32'hffffffff, 32'h0);
		// Second ratio is written while locked: bypass again at once
		for (int r = 3; r <= 5; r += 2) begin
			wr(PWLC_OFF_RATIO, r);
			@(negedge sys_clk);
			chk(clkSrc, SRC_OSC_DIV2);
			n = 0;
			while (clkSrc != SRC_PLL && n < 100) begin
				@(negedge sys_clk);
				n++;
			end
			chk(n >= LOCK - 2 && n <= LOCK + 2, 1'b1);
			chk(pllMult, r);
		end
		wr(PWLC_OFF_STATUS, 32'h1);
		rdChk(PWLC_OFF_STATUS, 32'h3, 32'h0);
		wr(PWLC_OFF_RATIO, 32'h0);
		wr(PWLC_OFF_STATUS, 32'h1);
		@(negedge sys_clk);
		chk(clkSrc, SRC_OSC);
		wr(PWLC_OFF_RATIO, 32'h4);
		rdChk(PWLC_OFF_RATIO, 32'hffffffff, 32'h0);
		wr(PWLC_OFF_STATUS, 32'h2);
		@(negedge sys_clk);
		chk(clkSrc, SRC_OSC_DIV2);
		rdChk(PWLC_OFF_STATUS, 32'h3, 32'h2);
		wr(PWLC_OFF_STATUS, 32'h0);
		// Watchdog key: a stray value disarms, other registers do not
		cyc(1100);
		wr(PWLC_OFF_WDKEY, 32'h55);
		wr(PWLC_OFF_WDKEY, 32'h12);
		wr(PWLC_OFF_WDKEY, 32'haa);
		rd(PWLC_OFF_WDCOUNT, c1);
		chk(c1 != 32'h0, 1'b1);
		wr(PWLC_OFF_WDKEY, 32'h55);
		wr(PWLC_OFF_WAKESEL, 32'h00000020);
		wr(PWLC_OFF_WDKEY, 32'haa);
		rdChk(PWLC_OFF_WDCOUNT, 32'hffffffff, 32'h0);
		// Oscillator lost: limp clock, sticky flag, frozen watchdog
		cyc(600);
		oscOn <= 1'b0;
		cyc(100);
		@(negedge sys_clk);
		chk(clkSrc, SRC_LIMP);
		rdChk(PWLC_OFF_STATUS, 32'h14, 32'h14);
		rd(PWLC_OFF_WDCOUNT, c1);
		cyc(1100);
		rdChk(PWLC_OFF_WDCOUNT, 32'hffffffff, c1);
		oscOn <= 1'b1;
		cyc(10);
		wr(PWLC_OFF_STATUS, 32'h4);
		rdChk(PWLC_OFF_STATUS, 32'h14, 32'h0);
		chk(clkSrc, SRC_OSC_DIV2);
		tryWake(2'h0, 4, 1, 1'b0);
		tryWake(2'h0, 4, 6, 1'b1);
		tryWake(2'h0, 0, 6, 1'b1);
		tryWake(2'h0, 1, 6, 1'b1);
		tryWake(2'h1, 3, 4, 1'b0);
		tryWake(2'h1, 3, 12, 1'b1);
		tryWake(2'h1, 4, 6, 1'b0);
		tryWake(2'h1, 2, 6, 1'b1);
		tryWake(2'h1, 0, 6, 1'b1);
		tryWake(2'h1, 1, 6, 1'b1);
		tryWake(2'h2, 3, 1, 1'b0);
		tryWake(2'h2, 3, 6, 1'b1);
		tryWake(2'h2, 2, 6, 1'b1);
		tryWake(2'h2, 0, 6, 1'b1);
		tryWake(2'h2, 1, 6, 1'b1);
		closeOut();
	end

	// Whole sequence needs about 3500 cycles
	initial begin
		#200000;
		miscompares++;
		closeOut();
	end
endmodule
